// ### pkg/cmd_defines.svh
/*
 Constants of the uplink command decoder: message fields, opcodes,
 configuration sub-codes, register offsets and reset values.
 Assumes inclusion by bare name from pkg/ on the include path.
*/
`ifndef CMD_DEFINES_SVH
`define CMD_DEFINES_SVH

// message layout: 33 bits, opcode on top, 24-bit payload below
`define OP_HI          32
`define OP_LO          27
`define PAY_HI         23
`define SUB_HI         23
`define SUB_LO         16
`define HW_RTC_BIT     23

// opcodes
`define OP_CFG         6'h01
`define OP_REC         6'h02
`define OP_TLM         6'h03
`define OP_RTC         6'h04
`define OP_HDR         6'h05
`define OP_DATA        6'h06

// configuration sub-codes
`define CFG_HWL_ON     8'h01
`define CFG_HWL_OFF    8'h02
`define CFG_BYP_ON     8'h03
`define CFG_BYP_OFF    8'h04
`define CFG_DIAG_ON    8'h05
`define CFG_DIAG_OFF   8'h06
`define CFG_SAFE_CLR   8'h07
`define CFG_ECHO_ON    8'h08
`define CFG_ECHO_OFF   8'h09
`define CFG_MOD_SEL    8'h0A
`define CFG_CPU_RST    8'h0B
`define CFG_CPU_REL    8'h0C
`define CFG_LOAD_C     8'h0D
`define CFG_LOAD_D     8'h0E
`define CFG_HWL_ADDR   8'h0F

// register byte offsets
`define REG_STATUS     8'h00
`define REG_CTRL       8'h04
`define REG_FAULT      8'h08
`define REG_STAT1      8'h0C
`define REG_MODSEL     8'h10

// reset values and counts
`define MODSEL_RST     16'h0000
`define HWL_ADDR_RST   16'h0000
`define BITS_PER_CMD   5'h18
`define DIAG_PULSES    5'h08
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ### pkg/cmd_pkg.sv
/*
 Types shared by the uplink command decoder and its remote-unit sender.
 Assumes nothing of its surroundings.
*/
package cmd_pkg;
   typedef enum logic [2:0] {MSG_NONE, MSG_CFG, MSG_REC, MSG_TLM, MSG_RTC, MSG_HDR, MSG_DATA} msg_class_t;
   typedef enum logic [1:0] {KIND_RTC, KIND_HDR, KIND_DATA} cif_kind_t;
   typedef enum logic [1:0] {SND_IDLE, SND_WAIT, SND_SHIFT} snd_state_t;
endpackage

// ### verif/tick_gen.sv
/*
 Timing module model: one-cycle 1.024 MHz and 25 kHz strobes on aclk.
 Assumes a free-running aclk and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module tick_gen #(
   parameter int P_FAST = 4,
   parameter int P_SLOW = 40
) (
   // system
   input  wire logic aclk,
   input  wire logic aresetn,
   // strobes
   output logic      tick_1m,
   output logic      tick_25k
);
   // shortened periods: true rates would make one frame thousands of cycles
   int cf;
   int cs;
   always_ff @(posedge aclk) begin
      cf <= (!aresetn || cf == P_FAST - 1) ? 0 : cf + 1;
      tick_1m <= aresetn && cf == P_FAST - 1;
   end
   always_ff @(posedge aclk) begin
      cs <= (!aresetn || cs == P_SLOW - 1) ? 0 : cs + 1;
      tick_25k <= aresetn && cs == P_SLOW - 1;
   end
endmodule
`default_nettype wire

// ### verif/uplink_command_decoder_tb_top.sv
/*
 Self-checking bench of the uplink command decoder.
 Assumes the tick_gen timing model on the same aclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cmd_defines.svh"
`define CK(n, e, a) begin n_checks++; if ((a) !== (e)) begin err_total++; \
   $display("[FAIL] %s exp %h got %h", n, e, a); end end
module uplink_command_decoder_tb_top;
   logic        aclk, aresetn, msg_valid, sel_a_cmd, sel_b_cmd, tick_1m, tick_25k, safe_init_pin, echo_bad;
   logic [32:0] msg_data;
   logic [15:0] rom_status1, hwl_addr_r;
   logic [7:0]  ru_fault, awaddr, araddr;
   logic [31:0] wdata, rdata, rd_d;
   logic [3:0]  wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp, cif_kind_r, rd_r;
   logic        cif_valid_r, cpu_reset, safe_int_r, hwl_we_r, rec_valid_r, tlm_valid_r, inhibit_r;
   logic        safe_relay_r, power_a_r, ru_clk, ru_gate, ru_data;
   logic [23:0] cif_word_r, ctrl_word_r, hwl_data_r;
   int          err_total, n_checks;
   tick_gen tick_gen_inst (.aclk, .aresetn, .tick_1m, .tick_25k);
   uplink_command_decoder uplink_command_decoder_inst (.aclk, .aresetn, .msg_valid, .msg_data, .sel_a_cmd,
      .sel_b_cmd, .tick_1m, .tick_25k, .safe_init_pin, .rom_status1, .cif_valid_r, .cif_kind_r, .cif_word_r,
      .cpu_reset, .safe_int_r, .hwl_we_r, .hwl_addr_r, .hwl_data_r, .rec_valid_r, .tlm_valid_r, .ctrl_word_r,
      .inhibit_r, .safe_relay_r, .module_sel_r(), .power_a_r, .power_b_r(), .ruif_we_r(), .ruif_sel_d_r(),
      .ruif_data_r(), .ru_clk, .ru_data, .ru_gate, .echo_bad, .ru_fault, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task stop_test;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task tmo(input int i);
      if (i >= 900) begin
         err_total++;
         stop_test;
      end
   endtask
   // ready and valid are read right after the edge: the values that edge sampled
   task rd(input logic [7:0] a);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      i = 0;
      do begin
         @(posedge aclk);
         i++;
      end while (i < 900 && arready !== 1'b1);
      arvalid <= 1'b0;
      while (i < 900 && rvalid !== 1'b1) begin
         @(posedge aclk);
         i++;
      end
      tmo(i);
      rd_d = rdata;
      rd_r = rresp;
      rready <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      logic aw_go, w_go;
      @(posedge aclk);
      {awaddr, wdata, wstrb} <= {a, d, 4'hF};
      {awvalid, wvalid, bready} <= 3'h7;
      aw_go = 1'b1;
      w_go = 1'b1;
      for (i = 0; i < 900 && (aw_go || w_go); i++) begin
         @(posedge aclk);
         if (aw_go && awready === 1'b1) begin
            aw_go = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_go && wready === 1'b1) begin
            w_go = 1'b0;
            wvalid <= 1'b0;
         end
      end
      while (i < 900 && bvalid !== 1'b1) begin
         @(posedge aclk);
         i++;
      end
      tmo(i);
      `CK("bresp", `RESP_OKAY, bresp)
      bready <= 1'b0;
   endtask
   task send(input logic [32:0] m);
      @(posedge aclk);
      msg_valid <= 1'b1;
      msg_data <= m;
      @(posedge aclk);
      msg_valid <= 1'b0;
      #1;
   endtask
   task cfg(input logic [7:0] s, input logic [15:0] v);
      send({`OP_CFG, 3'h0, s, v});
   endtask
   task t_reset;
      `CK("cpu_reset", 1'b0, cpu_reset)
      `CK("inhibit", 1'b1, inhibit_r)
      `CK("power_a", 1'b1, power_a_r)
      rd(`REG_STATUS);
      `CK("status", 32'h00000200, rd_d)
      rd(`REG_STAT1);
      `CK("stat1", 32'h0000A5C3, rd_d)
      rd(`REG_CTRL);
      `CK("echo", 32'h00000001, rd_d)
      rd(8'h40);
      `CK("unmapped", `RESP_SLVERR, rd_r)
      ru_fault <= 8'h05;
      rd(`REG_FAULT);
      `CK("fault", 32'h00000005, rd_d)
      ru_fault <= 8'h00;
      wr(`REG_FAULT, 32'h00000001);
      rd(`REG_FAULT);
      `CK("fault_w1c", 32'h00000004, rd_d)
   endtask
   task t_pass;
      for (int k = 0; k < 3; k++) begin
         send({`OP_RTC + 6'(k), 3'h0, 24'h0A5A00 + 24'(k)});
         `CK("cif_valid", 1'b1, cif_valid_r)
         `CK("cif_kind", 2'(k), cif_kind_r)
         `CK("cif_word", 24'h0A5A00 + 24'(k), cif_word_r)
      end
      send({6'h3F, 27'h1});
      `CK("unknown", 1'b0, cif_valid_r)
      send({`OP_REC, 27'h123456});
      `CK("rec", 1'b1, rec_valid_r)
      send({`OP_TLM, 27'h654321});
      `CK("tlm", 24'h654321, tlm_valid_r ? ctrl_word_r : 24'h0)
   endtask
   task t_hwl;
      cfg(`CFG_HWL_ADDR, 16'h0100);
      cfg(`CFG_HWL_ON, 16'h0002);
      `CK("hold", 1'b1, cpu_reset)
      for (int k = 0; k < 3; k++) begin
         send({`OP_DATA, 27'h00BE00});
         `CK("hwl_we", k < 2, hwl_we_r)
         `CK("hwl_data", 24'h00BE00, hwl_data_r)
         if (k < 2) `CK("hwl_addr", 16'h0100 + 16'(k), hwl_addr_r)
      end
      cfg(`CFG_HWL_OFF, 16'h0000);
      `CK("release", 1'b0, cpu_reset)
   endtask
   task t_ru(input logic [4:0] n);
      int c, i;
      logic pc;
      logic [23:0] w;
      c = 0;
      pc = 1'b0;
      w = 24'h000000;
      send({`OP_RTC, 27'h800055});
      `CK("rtc_cif", 1'b0, cif_valid_r)
      for (i = 0; i < 900 && ru_gate !== 1'b1; i++) @(negedge aclk);
      for (; i < 900 && ru_gate === 1'b1; i++) begin
         @(negedge aclk);
         if (ru_clk && !pc) begin
            c++;
            w = {w[22:0], ru_data};
         end
         pc = ru_clk;
      end
      tmo(i);
      `CK("ru_clocks", n, 5'(c))
      `CK("ru_bits", 24'h800055 >> (`BITS_PER_CMD - n), w)
   endtask
   task t_safe;
      cfg(`CFG_BYP_OFF, 16'h0000);
      cfg(`CFG_DIAG_OFF, 16'h0000);
      repeat (2) @(posedge aclk);
      `CK("inhibit_off", 1'b0, inhibit_r)
      safe_init_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      `CK("relay", 1'b1, safe_relay_r)
      rd(`REG_STATUS);
      `CK("safe_status", 32'h00000A00, rd_d)
      safe_init_pin <= 1'b0;
      cfg(`CFG_SAFE_CLR, 16'h0000);
      `CK("safe_clr", 1'b0, safe_int_r)
      wr(`REG_CTRL, 32'h0);
      rd(`REG_CTRL);
      `CK("echo_off", 32'h0, rd_d)
   endtask
   initial begin
      {aresetn, msg_valid, sel_a_cmd, sel_b_cmd, safe_init_pin, echo_bad} = 6'h0;
      {awvalid, wvalid, bready, arvalid, rready, msg_data, ru_fault} = 46'h0;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      rom_status1 = 16'hA5C3;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_pass;
      t_hwl;
      t_ru(`BITS_PER_CMD);
      cfg(`CFG_DIAG_ON, 16'h0000);
      t_ru(`DIAG_PULSES);
      t_safe;
      stop_test;
   end
endmodule
`default_nettype wire

// ### verilog/ru_sender.sv
/*
 Serialises one 24-bit real-time command to the remote-unit interface.
 Assumes 1.024 MHz and 25 kHz one-cycle strobes on aclk and an echo
 fault level from the remote-unit interface on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cmd_defines.svh"

module ru_sender (
   // system
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // command in
   input  wire logic        start,
   input  wire logic [23:0] word,
   input  wire logic        diag,
   input  wire logic        echo_en,
   output logic             busy,
   // timing strobes
   input  wire logic        tick_1m,
   input  wire logic        tick_25k,
   // remote-unit interface
   input  wire logic        echo_bad,
   output logic             ru_clk_r,
   output logic             ru_data_r,
   output logic             ru_gate_r
);
   cmd_pkg::snd_state_t state_r;
   logic [23:0]         shift_r;
   logic [4:0]          slot_r;
   logic [4:0]          pulses_r;
   logic                diag_r;
   logic                stop_r;
   logic                phase_r;
   logic [4:0]          limit;

   // diagnostic frames carry every data bit but too few clocks
   assign limit = diag_r ? `DIAG_PULSES : `BITS_PER_CMD;
   assign busy  = (state_r != cmd_pkg::SND_IDLE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r   <= cmd_pkg::SND_IDLE;
         shift_r   <= 24'h000000;
         slot_r    <= 5'h00;
         pulses_r  <= 5'h00;
         diag_r    <= 1'b0;
         stop_r    <= 1'b0;
         phase_r   <= 1'b0;
         ru_clk_r  <= 1'b0;
         ru_data_r <= 1'b0;
         ru_gate_r <= 1'b0;
      end else begin
         case (state_r)
            cmd_pkg::SND_IDLE: begin
               if (start) begin
                  shift_r  <= word;
                  diag_r   <= diag;
                  stop_r   <= 1'b0;
                  phase_r  <= 1'b0;
                  slot_r   <= 5'h00;
                  pulses_r <= 5'h00;
                  state_r  <= cmd_pkg::SND_WAIT;
               end
            end
            // frames start on the slow strobe so word gaps stay regular
            cmd_pkg::SND_WAIT: begin
               if (tick_25k) begin
                  ru_gate_r <= 1'b1;
                  state_r   <= cmd_pkg::SND_SHIFT;
               end
            end
            cmd_pkg::SND_SHIFT: begin
               if (echo_en && echo_bad) begin
                  stop_r   <= 1'b1;
                  ru_clk_r <= 1'b0;
               end else if (tick_1m) begin
                  // own phase bit: a withheld clock must not stall the slot count
                  phase_r <= !phase_r;
                  if (!phase_r) begin
                     ru_data_r <= shift_r[23];
                     if (!stop_r && pulses_r < limit) begin
                        ru_clk_r <= 1'b1;
                        pulses_r <= pulses_r + 5'h01;
                     end
                     if (slot_r == `BITS_PER_CMD) begin
                        ru_gate_r <= 1'b0;
                        ru_clk_r  <= 1'b0;
                        phase_r   <= 1'b0;
                        state_r   <= cmd_pkg::SND_IDLE;
                     end
                  end else begin
                     ru_clk_r <= 1'b0;
                     shift_r  <= {shift_r[22:0], 1'b0};
                     slot_r   <= slot_r + 5'h01;
                  end
               end
            end
            default: state_r <= cmd_pkg::SND_IDLE;
         endcase
      end
   end

   echo_stop_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         (state_r == cmd_pkg::SND_SHIFT && echo_en && echo_bad) |=> !ru_clk_r)
      else $error("remote-unit clock ran after a bad echo");

   diag_short_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         (diag_r && busy) |-> pulses_r <= `DIAG_PULSES)
      else $error("diagnostic frame gave too many clock pulses");
endmodule
`default_nettype wire

// ### verilog/uplink_command_decoder.sv
/*
 Uplink command decoder: classifies 33-bit uplink messages, runs the
 configuration commands, forwards module control, feeds the computer
 and the remote-unit sender, and exposes status over AXI4-Lite.
 Assumes uplink messages, selection pulses, timing strobes and echo
 status come from logic on aclk; only the safe-mode pin is asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cmd_defines.svh"

module uplink_command_decoder #(
   parameter int FAULT_W = 8,
   parameter bit UNIT_B  = 1'b0
) (
   // system
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // uplink interface
   input  wire logic               msg_valid,
   input  wire logic [32:0]        msg_data,
   input  wire logic               sel_a_cmd,
   input  wire logic               sel_b_cmd,
   // timing module strobes
   input  wire logic               tick_1m,
   input  wire logic               tick_25k,
   // power supply electronics
   input  wire logic               safe_init_pin,
   // telemetry ROM
   input  wire logic [15:0]        rom_status1,
   // computer interface module
   output logic                    cif_valid_r,
   output logic [1:0]              cif_kind_r,
   output logic [23:0]             cif_word_r,
   output logic                    cpu_reset,
   output logic                    safe_int_r,
   output logic                    hwl_we_r,
   output logic [15:0]             hwl_addr_r,
   output logic [23:0]             hwl_data_r,
   // unit module control
   output logic                    rec_valid_r,
   output logic                    tlm_valid_r,
   output logic [23:0]             ctrl_word_r,
   output logic                    inhibit_r,
   output logic                    safe_relay_r,
   output logic [15:0]             module_sel_r,
   output logic                    power_a_r,
   output logic                    power_b_r,
   // remote-unit interface
   output logic                    ruif_we_r,
   output logic                    ruif_sel_d_r,
   output logic [23:0]             ruif_data_r,
   output logic                    ru_clk,
   output logic                    ru_data,
   output logic                    ru_gate,
   input  wire logic               echo_bad,
   input  wire logic [FAULT_W-1:0] ru_fault,
   // AXI4-Lite slave
   input  wire logic [7:0]         awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   input  wire logic [7:0]         araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready
);
   if (FAULT_W < 1 || FAULT_W > 8) begin : g_bad_fault_w
      $error("FAULT_W must lie in 1..8");
   end

   cmd_pkg::msg_class_t cls;
   logic [23:0]         pay;
   logic [7:0]          sub;
   logic                active, take, cfg;
   logic                hwl_r, bypass_r, diag_r, echo_en_r, cpu_hold_r;
   logic [7:0]          hwl_left_r;
   logic                safe_s1_r, safe_s2_r, safe_d_r, safe_rise;
   logic                snd_start, snd_busy;
   logic [FAULT_W-1:0]  fault_r;
   logic [15:0]         status1_r;

   // redundant pair: only the powered unit listens
   assign active = UNIT_B ? power_b_r : power_a_r;
   assign take   = msg_valid && active;
   assign pay    = msg_data[`PAY_HI:0];
   assign sub    = msg_data[`SUB_HI:`SUB_LO];
   assign cfg    = take && cls == cmd_pkg::MSG_CFG;

   always_comb begin
      case (msg_data[`OP_HI:`OP_LO])
         `OP_CFG:  cls = cmd_pkg::MSG_CFG;
         `OP_REC:  cls = cmd_pkg::MSG_REC;
         `OP_TLM:  cls = cmd_pkg::MSG_TLM;
         `OP_RTC:  cls = cmd_pkg::MSG_RTC;
         `OP_HDR:  cls = cmd_pkg::MSG_HDR;
         `OP_DATA: cls = cmd_pkg::MSG_DATA;
         default:  cls = cmd_pkg::MSG_NONE;
      endcase
   end

   // safe-mode pin is asynchronous
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         safe_s1_r <= 1'b0;
         safe_s2_r <= 1'b0;
         safe_d_r  <= 1'b0;
      end else begin
         safe_s1_r <= safe_init_pin;
         safe_s2_r <= safe_s1_r;
         safe_d_r  <= safe_s2_r;
      end
   end
   assign safe_rise = safe_s2_r && !safe_d_r;

   // configuration state; computer writes cannot touch bypass or diag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hwl_r        <= 1'b0;
         bypass_r     <= 1'b1;
         diag_r       <= 1'b0;
         cpu_hold_r   <= 1'b0;
         module_sel_r <= `MODSEL_RST;
      end else begin
         if (cfg) begin
            case (sub)
               `CFG_HWL_ON:  hwl_r <= (pay[7:0] != 8'h00);
               `CFG_HWL_OFF: hwl_r <= 1'b0;
               `CFG_BYP_ON:  bypass_r <= 1'b1;
               `CFG_BYP_OFF: bypass_r <= 1'b0;
               `CFG_DIAG_ON:  diag_r <= 1'b1;
               `CFG_DIAG_OFF: diag_r <= 1'b0;
               `CFG_CPU_RST: cpu_hold_r <= 1'b1;
               `CFG_CPU_REL: cpu_hold_r <= 1'b0;
               `CFG_MOD_SEL: module_sel_r <= pay[15:0];
               default: ;
            endcase
         end
         if (safe_rise) begin
            bypass_r <= 1'b1;
         end
      end
   end

   assign cpu_reset = hwl_r || cpu_hold_r;

   // hardware load: data words go straight to computer memory
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hwl_left_r <= 8'h00;
         hwl_addr_r <= `HWL_ADDR_RST;
         hwl_we_r   <= 1'b0;
         hwl_data_r <= 24'h000000;
      end else begin
         hwl_we_r <= 1'b0;
         if (cfg && sub == `CFG_HWL_ON) begin
            hwl_left_r <= pay[7:0];
         end else if (cfg && sub == `CFG_HWL_ADDR) begin
            hwl_addr_r <= pay[15:0];
         end else if (take && cls == cmd_pkg::MSG_DATA && hwl_r && hwl_left_r != 8'h00) begin
            hwl_we_r   <= 1'b1;
            hwl_data_r <= pay;
            hwl_left_r <= hwl_left_r - 8'h01;
         end
         if (hwl_we_r) begin
            hwl_addr_r <= hwl_addr_r + 16'h0001;
         end
      end
   end

   // routing of control, computer and remote-unit words
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cif_valid_r  <= 1'b0;
         cif_kind_r   <= 2'h0;
         cif_word_r   <= 24'h000000;
         rec_valid_r  <= 1'b0;
         tlm_valid_r  <= 1'b0;
         ctrl_word_r  <= 24'h000000;
         ruif_we_r    <= 1'b0;
         ruif_sel_d_r <= 1'b0;
         ruif_data_r  <= 24'h000000;
      end else begin
         cif_valid_r <= 1'b0;
         rec_valid_r <= 1'b0;
         tlm_valid_r <= 1'b0;
         ruif_we_r   <= 1'b0;
         if (take && (cls == cmd_pkg::MSG_REC || cls == cmd_pkg::MSG_TLM)) begin
            rec_valid_r <= (cls == cmd_pkg::MSG_REC);
            tlm_valid_r <= (cls == cmd_pkg::MSG_TLM);
            ctrl_word_r <= pay;
         end
         if (take && !snd_start && ((cls == cmd_pkg::MSG_RTC) || (cls == cmd_pkg::MSG_HDR) ||
             (cls == cmd_pkg::MSG_DATA && !hwl_r))) begin
            cif_valid_r <= 1'b1;
            cif_word_r  <= pay;
            cif_kind_r  <= (cls == cmd_pkg::MSG_RTC) ? cmd_pkg::KIND_RTC :
                           (cls == cmd_pkg::MSG_HDR) ? cmd_pkg::KIND_HDR : cmd_pkg::KIND_DATA;
         end
         if (cfg && (sub == `CFG_LOAD_C || sub == `CFG_LOAD_D)) begin
            ruif_we_r    <= 1'b1;
            ruif_sel_d_r <= (sub == `CFG_LOAD_D);
            ruif_data_r  <= {8'h00, pay[15:0]};
         end
      end
   end

   // in bypass or diagnostic, hardware commands go direct; one arriving while busy is dropped
   assign snd_start = take && cls == cmd_pkg::MSG_RTC && pay[`HW_RTC_BIT] && (bypass_r || diag_r);

   ru_sender u_sender (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .start     (snd_start && !snd_busy),
      .word      (pay),
      .diag      (diag_r),
      .echo_en   (echo_en_r),
      .busy      (snd_busy),
      .tick_1m   (tick_1m),
      .tick_25k  (tick_25k),
      .echo_bad  (echo_bad),
      .ru_clk_r  (ru_clk),
      .ru_data_r (ru_data),
      .ru_gate_r (ru_gate)
   );

   // safe mode, inhibits and unit power
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         safe_int_r   <= 1'b0;
         safe_relay_r <= 1'b0;
         inhibit_r    <= 1'b1;
         power_a_r    <= 1'b1;
         power_b_r    <= 1'b0;
      end else begin
         // a new initiate beats a simultaneous clear
         safe_int_r   <= safe_rise || (safe_int_r && !(cfg && sub == `CFG_SAFE_CLR));
         safe_relay_r <= safe_s2_r;
         inhibit_r    <= bypass_r || diag_r;
         if (sel_a_cmd) begin
            power_a_r <= 1'b1;
            power_b_r <= 1'b0;
         end else if (sel_b_cmd) begin
            power_a_r <= 1'b0;
            power_b_r <= 1'b1;
         end
      end
   end

   // AXI4-Lite: address and data may arrive in either order
   logic       aw_ok_r, w_ok_r, wr_go;
   logic [7:0] aw_addr_r;
   logic [7:0] w_low_r;
   logic       w_lane0_r;

   assign awready = !aw_ok_r && !bvalid;
   assign wready  = !w_ok_r && !bvalid;
   assign arready = !rvalid;
   assign wr_go   = aw_ok_r && w_ok_r && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_r   <= 1'b0;
         w_ok_r    <= 1'b0;
         aw_addr_r <= 8'h00;
         w_low_r   <= 8'h00;
         w_lane0_r <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= `RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_ok_r   <= 1'b1;
            aw_addr_r <= awaddr;
         end
         if (wvalid && wready) begin
            w_ok_r    <= 1'b1;
            w_low_r   <= wdata[7:0];
            w_lane0_r <= wstrb[0];
         end
         if (wr_go) begin
            aw_ok_r <= 1'b0;
            w_ok_r  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= (aw_addr_r <= `REG_MODSEL && aw_addr_r[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // echo checking: ground or computer may change it, ground wins in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         echo_en_r <= 1'b1;
      end else if (cfg && (sub == `CFG_ECHO_ON || sub == `CFG_ECHO_OFF)) begin
         echo_en_r <= (sub == `CFG_ECHO_ON);
      end else if (wr_go && aw_addr_r == `REG_CTRL && w_lane0_r) begin
         echo_en_r <= w_low_r[0];
      end
   end

   // sticky remote-unit faults, write one to clear, new fault wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_r   <= '0;
         status1_r <= rom_status1;
      end else begin
         if (wr_go && aw_addr_r == `REG_FAULT && w_lane0_r) begin
            fault_r <= (fault_r & ~w_low_r[FAULT_W-1:0]) | ru_fault;
         end else begin
            fault_r <= fault_r | ru_fault;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp  <= `RESP_OKAY;
         case (araddr)
            `REG_STATUS: rdata <= {19'h00000, cpu_reset, safe_int_r, diag_r, bypass_r, hwl_r, hwl_left_r};
            `REG_CTRL:   rdata <= {31'h00000000, echo_en_r};
            `REG_FAULT:  rdata <= {{(32-FAULT_W){1'b0}}, fault_r};
            `REG_STAT1:  rdata <= {16'h0000, status1_r};
            `REG_MODSEL: rdata <= {16'h0000, module_sel_r};
            default: begin
               rdata <= 32'h00000000;
               rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence safe_edge_s;
      !safe_s2_r ##1 safe_s2_r;
   endsequence

   safe_enter_a:
      assert property (safe_edge_s |=> bypass_r && safe_int_r)
      else $error("safe initiate did not force bypass and interrupt");
   safe_relay_a:
      assert property (safe_edge_s |=> safe_relay_r)
      else $error("safe initiate not relayed");
   bypass_keep_a:
      assert property (bypass_r && !(cfg && sub == `CFG_BYP_OFF) |=> bypass_r)
      else $error("bypass cleared without ground command");
   diag_keep_a:
      assert property (!(cfg && (sub == `CFG_DIAG_ON || sub == `CFG_DIAG_OFF)) |=> $stable(diag_r))
      else $error("diagnostic mode changed without ground command");
   hwl_reset_a:
      assert property (hwl_r |-> cpu_reset)
      else $error("processor running during hardware load");
   hwl_write_a:
      assert property (take && cls == cmd_pkg::MSG_DATA && hwl_r && hwl_left_r != 8'h00
         |=> hwl_we_r && !cif_valid_r && hwl_data_r == $past(pay))
      else $error("hardware load word not written");
   rec_fwd_a:
      assert property (take && cls == cmd_pkg::MSG_REC |=> rec_valid_r && ctrl_word_r == $past(pay))
      else $error("recorder control not forwarded");
   hdr_cif_a:
      assert property (take && cls == cmd_pkg::MSG_HDR |=> cif_valid_r && cif_kind_r == cmd_pkg::KIND_HDR)
      else $error("header not passed to computer");
   unknown_a:
      assert property (take && cls == cmd_pkg::MSG_NONE
         |=> !cif_valid_r && !rec_valid_r && !tlm_valid_r && !ruif_we_r && $stable(bypass_r))
      else $error("unknown opcode had an effect");
   inhibit_a:
      assert property ((bypass_r || diag_r) ##1 (bypass_r || diag_r) |-> inhibit_r)
      else $error("inhibit not driven in bypass or diagnostic");
   one_unit_a:
      assert property (power_a_r != power_b_r)
      else $error("both or neither unit powered");
endmodule
`default_nettype wire
